// ===== rtl/timer_ctrl_params.svh
// Register offsets, field positions and reset values of the timer waveform control block.
//
// Behaviour
// - Setup holds mode 2:0, autolock 3, enables 6:4.
// - Enabled channel pin follows waveform when generating.
// - Autolock holds lock until enabled buffers valid.
// - Lock stays clear until update, then sets.
// - Without autolock, only software changes lock.
// - Mode codes 0,1,3,5,6,7; others reserved.
// - Each mode picks TOP, update and overflow points.
// - Normal mode drives no waveform onto pins.
// - Disabled timer: level writes set waveform outputs.
// - Split bit selects two eight-bit timers.
// - Clear register: writing one clears status bit.
// - Set register: writing one sets status bit.
// - Lock and direction read alike in both.
// - Command 3:2, lock 1, direction 0.
// - Commands: none, update, restart, hard reset.
// - Command field always reads as zero.
// - Lock high blocks buffer copy on update.
// - Direction zero counts up, one down.
// - Buffer valid set on write, cleared on unlocked update.
// - Enable bit gates level writes and hard reset.
`ifndef TIMER_CTRL_PARAMS_SVH
`define TIMER_CTRL_PARAMS_SVH

// Register indices; byte address is four times the index.
`define IDX_WAVEFORM_SETUP 4'h1
`define IDX_OUTPUT_LEVELS  4'h2
`define IDX_SPLIT_CONTROL  4'h3
`define IDX_STATUS_CLEAR   4'h4
`define IDX_STATUS_SET     4'h5

// Field positions of the waveform setup register.
`define WS_MODE_MSB   2
`define WS_MODE_LSB   0
`define WS_AUTO_LOCK  3
`define WS_EN_MSB     6
`define WS_EN_LSB     4

// Field positions of the command and status registers.
`define ST_CMD_MSB    3
`define ST_CMD_LSB    2
`define ST_LOCK       1
`define ST_DIR        0

// Split mode bit position.
`define SPLIT_BIT     0

// Reset values.
`define RST_WAVEFORM_SETUP 8'h00
`define RST_OUTPUT_LEVELS  3'h0
`define RST_STATUS_BIT     1'b0
`define RST_SPLIT          1'b0

`endif

// ===== rtl/timer_ctrl_pkg.sv
// Types shared by the timer waveform control block.
package timer_ctrl_pkg;

	// Waveform generation mode codes as held in the setup register.
	typedef enum logic [2:0] {
		MODE_NORMAL      = 3'h0,
		MODE_FREQUENCY   = 3'h1,
		MODE_ONE_RAMP    = 3'h3,
		MODE_TWO_TOP     = 3'h5,
		MODE_TWO_BOTH    = 3'h6,
		MODE_TWO_BOTTOM  = 3'h7
	} wave_mode_t;

	// Software command codes.
	typedef enum logic [1:0] {
		CMD_NONE       = 2'h0,
		CMD_UPDATE     = 2'h1,
		CMD_RESTART    = 2'h2,
		CMD_HARD_RESET = 2'h3
	} cmd_t;

	// Automatic lock sequencer states.
	typedef enum logic {
		LOCK_HOLD,
		LOCK_OPEN
	} lock_state_t;

endpackage

// ===== rtl/timer_waveform_control_regs.sv
// Control registers and mode decode of a sixteen-bit timer with three compare channels.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
`include "timer_ctrl_params.svh"

module timer_waveform_control_regs
	import timer_ctrl_pkg::*;
#(
	parameter int CHANNELS = 3
) (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                rst,
	// Avalon-MM slave.
	input  wire logic [5:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	// Timer core status.
	input  wire logic                timer_enabled,
	input  wire logic                update_condition,
	input  wire logic [CHANNELS-1:0] buffer_written,
	input  wire logic                hw_dir_load,
	input  wire logic                hw_dir_value,
	// Waveform generator and port levels.
	input  wire logic [CHANNELS-1:0] wg_level,
	input  wire logic [CHANNELS-1:0] port_level,
	// Timer core controls.
	output logic                     copy_buffers,
	output logic                     force_update,
	output logic                     force_restart,
	output logic                     force_hard_reset,
	output logic                     count_down,
	output logic                     top_from_compare0,
	output logic                     update_at_bottom,
	output logic                     overflow_at_top,
	output logic                     overflow_at_bottom,
	output logic                     split_mode,
	output logic [CHANNELS-1:0]      buffer_valid_flag,
	// Waveform levels and pins.
	output logic [CHANNELS-1:0]      waveform_level,
	output logic [CHANNELS-1:0]      waveform_output_pin,
	output logic [CHANNELS-1:0]      pin_override
);

	////////////////////////////////////////////////////////////////////////////
	// Register state.

	// Waveform setup: mode, auto lock and compare enables.
	logic [7:0]          waveform_setup;
	// Levels written for the waveform outputs while stopped.
	logic [CHANNELS-1:0] compare_output_value;
	// Split mode selection.
	logic                split_mode_select;
	// Lock on buffered copies.
	logic                update_lock;
	// Automatic lock sequencer state.
	lock_state_t         lock_state;

	// Field views of the setup register.
	wave_mode_t          waveform_mode;
	logic                auto_lock_update;
	logic [CHANNELS-1:0] compare_output_enable;

	assign waveform_mode         = wave_mode_t'(waveform_setup[`WS_MODE_MSB:`WS_MODE_LSB]);
	assign auto_lock_update      = waveform_setup[`WS_AUTO_LOCK];
	assign compare_output_enable = waveform_setup[`WS_EN_MSB:`WS_EN_LSB];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// Register index taken from the word address.
	logic [3:0] reg_index;
	// Write completes at this edge.
	logic       wr_done;
	// Read data is captured at this edge.
	logic       rd_take;
	// Writes aimed at the set and clear registers.
	logic       set_wr;
	logic       clr_wr;
	// Command written and its decoded effects.
	cmd_t       cmd_in;
	logic       cmd_wr;
	logic       hard_reset_take;
	logic       update_take;
	// Copy happens in this cycle.
	logic       copy_now;
	// All enabled compare buffers hold fresh values.
	logic       all_valid;

	assign reg_index = address[5:2];
	assign wr_done   = write && !waitrequest && byteenable[0];
	assign rd_take   = read && waitrequest;
	assign set_wr    = wr_done && (reg_index == `IDX_STATUS_SET);
	assign clr_wr    = wr_done && (reg_index == `IDX_STATUS_CLEAR);
	assign cmd_in    = cmd_t'(writedata[`ST_CMD_MSB:`ST_CMD_LSB]);
	assign cmd_wr    = set_wr || clr_wr;

	assign hard_reset_take = cmd_wr && (cmd_in == CMD_HARD_RESET) && !timer_enabled;
	assign update_take     = update_condition || (cmd_wr && (cmd_in == CMD_UPDATE));

	assign copy_now  = update_take && !update_lock;
	assign all_valid = &(buffer_valid_flag | ~compare_output_enable);

	// Wait state generator: one wait cycle, then waitrequest low for one cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Read value multiplexer; unmapped addresses read as zero.
	logic [31:0] read_value;
	always_comb begin
		read_value = 32'h0000_0000;
		case (reg_index)
			`IDX_WAVEFORM_SETUP: begin
				read_value[7:0] = waveform_setup;
			end
			`IDX_OUTPUT_LEVELS: begin
				read_value[CHANNELS-1:0] = compare_output_value;
			end
			`IDX_SPLIT_CONTROL: begin
				read_value[`SPLIT_BIT] = split_mode_select;
			end
			`IDX_STATUS_CLEAR, `IDX_STATUS_SET: begin
				read_value[`ST_LOCK] = update_lock;
				read_value[`ST_DIR]  = count_down;
			end
			default: begin
				read_value = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured while the wait cycle runs and held until the next read.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			readdata <= read_value;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	// Setup register; bit 7 has no storage and reads zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waveform_setup <= `RST_WAVEFORM_SETUP;
		end else if (hard_reset_take) begin
			waveform_setup <= `RST_WAVEFORM_SETUP;
		end else if (wr_done && (reg_index == `IDX_WAVEFORM_SETUP)) begin
			waveform_setup <= {1'b0, writedata[6:0]};
		end
	end

	// Stored levels change only while the timer is stopped.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_output_value <= `RST_OUTPUT_LEVELS;
		end else if (hard_reset_take) begin
			compare_output_value <= `RST_OUTPUT_LEVELS;
		end else if (wr_done && (reg_index == `IDX_OUTPUT_LEVELS) && !timer_enabled) begin
			compare_output_value <= writedata[CHANNELS-1:0];
		end
	end

	// Split mode bit; the timer core rebuilds its counters and map from it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			split_mode_select <= `RST_SPLIT;
		end else if (hard_reset_take) begin
			split_mode_select <= `RST_SPLIT;
		end else if (wr_done && (reg_index == `IDX_SPLIT_CONTROL)) begin
			split_mode_select <= writedata[`SPLIT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lock and direction status.

	// Lock: sequenced by hardware under auto lock, else by software writes only.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			update_lock <= `RST_STATUS_BIT;
			lock_state  <= LOCK_HOLD;
		end else if (hard_reset_take) begin
			update_lock <= `RST_STATUS_BIT;
			lock_state  <= LOCK_HOLD;
		end else if (auto_lock_update) begin
			case (lock_state)
				LOCK_HOLD: begin
					if (all_valid) begin
						update_lock <= 1'b0;
						lock_state  <= LOCK_OPEN;
					end else begin
						update_lock <= 1'b1;
					end
				end
				LOCK_OPEN: begin
					if (update_take) begin
						update_lock <= 1'b1;
						lock_state  <= LOCK_HOLD;
					end else begin
						update_lock <= 1'b0;
					end
				end
				default: begin
					lock_state <= LOCK_HOLD;
				end
			endcase
		end else begin
			lock_state <= LOCK_HOLD;
			if (set_wr && writedata[`ST_LOCK]) begin
				update_lock <= 1'b1;
			end else if (clr_wr && writedata[`ST_LOCK]) begin
				update_lock <= 1'b0;
			end
		end
	end

	// Direction: software write first, then a hardware load from the core.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_down <= `RST_STATUS_BIT;
		end else if (hard_reset_take) begin
			count_down <= `RST_STATUS_BIT;
		end else if (set_wr && writedata[`ST_DIR]) begin
			count_down <= 1'b1;
		end else if (clr_wr && writedata[`ST_DIR]) begin
			count_down <= 1'b0;
		end else if (hw_dir_load) begin
			count_down <= hw_dir_value;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Commands and buffered copy.

	// One-cycle command strobes toward the timer core.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			force_update     <= 1'b0;
			force_restart    <= 1'b0;
			force_hard_reset <= 1'b0;
		end else begin
			force_update     <= cmd_wr && (cmd_in == CMD_UPDATE);
			force_restart    <= cmd_wr && (cmd_in == CMD_RESTART);
			force_hard_reset <= hard_reset_take;
		end
	end

	// Copy strobe: buffers move into the compare registers this cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			copy_buffers <= 1'b0;
		end else begin
			copy_buffers <= copy_now;
		end
	end

	// Buffer valid flags: a buffer write wins over a copy in the same cycle.
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_valid
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					buffer_valid_flag[ch] <= 1'b0;
				end else if (hard_reset_take) begin
					buffer_valid_flag[ch] <= 1'b0;
				end else if (buffer_written[ch]) begin
					buffer_valid_flag[ch] <= 1'b1;
				end else if (copy_now) begin
					buffer_valid_flag[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Mode decode.

	// Waveform generated in any known mode other than normal.
	logic waveform_active;
	always_comb begin
		waveform_active = 1'b0;
		case (waveform_mode)
			MODE_FREQUENCY, MODE_ONE_RAMP, MODE_TWO_TOP, MODE_TWO_BOTH, MODE_TWO_BOTTOM: begin
				waveform_active = 1'b1;
			end
			default: begin
				waveform_active = 1'b0;
			end
		endcase
	end

	// TOP source, update point and overflow points per mode; reserved acts as normal.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_from_compare0  <= 1'b0;
			update_at_bottom   <= 1'b0;
			overflow_at_top    <= 1'b1;
			overflow_at_bottom <= 1'b0;
		end else begin
			top_from_compare0  <= (waveform_mode == MODE_FREQUENCY);
			update_at_bottom   <= (waveform_mode == MODE_ONE_RAMP) ||
				(waveform_mode == MODE_TWO_TOP) ||
				(waveform_mode == MODE_TWO_BOTH) ||
				(waveform_mode == MODE_TWO_BOTTOM);
			overflow_at_top    <= (waveform_mode != MODE_ONE_RAMP) &&
				(waveform_mode != MODE_TWO_BOTTOM);
			overflow_at_bottom <= (waveform_mode == MODE_ONE_RAMP) ||
				(waveform_mode == MODE_TWO_BOTH) ||
				(waveform_mode == MODE_TWO_BOTTOM);
		end
	end

	// Split mode output toward the core.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			split_mode <= `RST_SPLIT;
		end else begin
			split_mode <= split_mode_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Waveform levels and pin override.

	// Output levels: generator while running, stored values while stopped.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waveform_level <= `RST_OUTPUT_LEVELS;
		end else if (timer_enabled) begin
			waveform_level <= wg_level;
		end else begin
			waveform_level <= compare_output_value;
		end
	end

	// Per-channel pin selection.
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_pin
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					waveform_output_pin[ch] <= 1'b0;
					pin_override[ch]        <= 1'b0;
				end else if (waveform_active && compare_output_enable[ch]) begin
					waveform_output_pin[ch] <= waveform_level[ch];
					pin_override[ch]        <= 1'b1;
				end else begin
					waveform_output_pin[ch] <= port_level[ch];
					pin_override[ch]        <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_lock_hold_set: assert property (
		auto_lock_update && (lock_state == LOCK_HOLD) && !all_valid && !hard_reset_take
		|=> update_lock)
		else $error("Lock not held while buffers incomplete.");

	a_lock_auto_clear: assert property (
		auto_lock_update && (lock_state == LOCK_HOLD) && all_valid && !hard_reset_take
		|=> !update_lock && (lock_state == LOCK_OPEN))
		else $error("Lock not cleared once buffers valid.");

	a_lock_relock: assert property (
		auto_lock_update && (lock_state == LOCK_OPEN) && update_take && !hard_reset_take
		|-> copy_now ##1 (update_lock && copy_buffers))
		else $error("Update in open state did not copy and relock.");

	a_lock_manual: assert property (
		!auto_lock_update && !cmd_wr && !$past(auto_lock_update) |=> $stable(update_lock))
		else $error("Lock moved without software write.");

	a_copy_blocked: assert property (
		update_take && update_lock |=> !copy_buffers)
		else $error("Buffers copied while locked.");

	a_cmd_read_zero: assert property (
		read && !waitrequest && ((reg_index == `IDX_STATUS_SET) ||
		(reg_index == `IDX_STATUS_CLEAR)) |-> (readdata[3:2] == 2'h0))
		else $error("Command field read back nonzero.");

	a_hard_reset_gate: assert property (
		force_hard_reset |-> !$past(timer_enabled) && $past(cmd_wr))
		else $error("Hard reset issued while timer enabled.");

	a_valid_set: assert property (
		buffer_written[0] && !hard_reset_take |=> buffer_valid_flag[0] [*1])
		else $error("Valid flag not set after buffer write.");

	a_normal_no_wave: assert property (
		(waveform_mode == MODE_NORMAL) |=> (pin_override == '0))
		else $error("Pin overridden in normal mode.");

	a_level_direct: assert property (
		!timer_enabled ##1 !timer_enabled |-> waveform_level == $past(compare_output_value))
		else $error("Stopped level does not follow stored value.");

endmodule

// ===== tb/test_timer_waveform_control_regs.sv
// Self-checking testbench of the timer waveform control register block.
`timescale 1ns/100ps
`include "timer_ctrl_params.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); n_fail++; end end

module test_timer_waveform_control_regs;
	import timer_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals.
	logic        clk;               // Bench clock, 5 ns period.
	logic        rst;               // Asynchronous reset, active high.
	logic [5:0]  address;           // Avalon byte address.
	logic        read;              // Avalon read request.
	logic        write;             // Avalon write request.
	logic [31:0] writedata;         // Avalon write data.
	logic [3:0]  byteenable;        // Avalon byte lanes.
	logic [31:0] readdata;          // Avalon read data.
	logic        waitrequest;       // Avalon wait, low for one cycle.
	logic        timer_enabled;     // Timer running flag.
	logic        update_condition;  // Update pulse from the core.
	logic [2:0]  buffer_written;    // Compare buffer write pulses.
	logic        hw_dir_load;       // Hardware direction load pulse.
	logic        hw_dir_value;      // Hardware direction value.
	logic [2:0]  wg_level;          // Waveform generator levels.
	logic [2:0]  port_level;        // Port register levels.
	logic        copy_buffers, force_update, force_restart, force_hard_reset;
	logic        count_down, top_from_compare0, update_at_bottom;
	logic        overflow_at_top, overflow_at_bottom, split_mode;
	logic [2:0]  buffer_valid_flag, waveform_level, waveform_output_pin, pin_override;
	int          n_fail, num_checks;           // Mismatch and comparison counters.
	int          n_upd, n_rst, n_hrd, n_copy;  // Strobe pulse counters.
	logic [7:0]  exp_q[$];                     // Expected read data, oldest first.
	logic [7:0]  lf;                           // Random state.

	// Device under test.
	timer_waveform_control_regs #(.CHANNELS(3)) dut (
		.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .timer_enabled(timer_enabled),
		.update_condition(update_condition), .buffer_written(buffer_written),
		.hw_dir_load(hw_dir_load), .hw_dir_value(hw_dir_value), .wg_level(wg_level),
		.port_level(port_level), .copy_buffers(copy_buffers), .force_update(force_update),
		.force_restart(force_restart), .force_hard_reset(force_hard_reset),
		.count_down(count_down), .top_from_compare0(top_from_compare0),
		.update_at_bottom(update_at_bottom), .overflow_at_top(overflow_at_top),
		.overflow_at_bottom(overflow_at_bottom), .split_mode(split_mode),
		.buffer_valid_flag(buffer_valid_flag), .waveform_level(waveform_level),
		.waveform_output_pin(waveform_output_pin), .pin_override(pin_override));

	////////////////////////////////////////////////////////////////////////////////
	// Clock generation.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Shift register that supplies the random values.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Waits some edges, then stops at the falling edge where outputs are settled.
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// One Avalon transfer held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
			input logic [3:0] be);
		int n;
		@(posedge clk);
		address    <= {idx, 2'b00};
		write      <= wr;
		read       <= ~wr;
		writedata  <= {24'h000000, d};
		byteenable <= be;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_fail++;
			wrap_up();
		end
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	// Register write through all lanes.
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'hF);
	endtask

	// Register read; the expectation is queued for the monitor.
	task automatic rd(input logic [3:0] idx, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, idx, 8'h00, 4'hF);
	endtask

	// One-cycle pulse on a core input: 0 buffer write, 1 update, 2 direction load.
	task automatic pulse(input int sel, input logic [2:0] v);
		@(posedge clk);
		case (sel)
			0: buffer_written <= v;
			1: update_condition <= 1'b1;
			default: begin
				hw_dir_load  <= 1'b1;
				hw_dir_value <= v[0];
			end
		endcase
		@(posedge clk);
		buffer_written   <= 3'h0;
		update_condition <= 1'b0;
		hw_dir_load      <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: each completed read takes the oldest expectation.
	always @(posedge clk) begin
		logic [31:0] e_rd;
		if (read === 1'b1 && waitrequest === 1'b0) begin
			e_rd = {24'h000000, exp_q.pop_front()};
			`CHK("readdata", e_rd, readdata)
		end
	end

	// Counts the strobes that leave the block.
	always @(posedge clk) begin
		if (force_update === 1'b1) n_upd++;
		if (force_restart === 1'b1) n_rst++;
		if (force_hard_reset === 1'b1) n_hrd++;
		if (copy_buffers === 1'b1) n_copy++;
	end

	// Watchdog that cuts a hang short.
	initial begin
		repeat (6000) @(posedge clk);
		n_fail++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [7:0] sd;
		logic [2:0] en, wg, pt, ov;
		logic       vm;
		{address, read, write, writedata, byteenable} = '0;
		{timer_enabled, update_condition, buffer_written, hw_dir_load, hw_dir_value} = '0;
		{wg_level, port_level} = '0;
		{n_fail, num_checks, n_upd, n_rst, n_hrd, n_copy} = '0;
		lf  = 8'h58;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 1; i < 6; i++) rd(i[3:0], 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		for (int m = 0; m < 8; m++) begin
			lf = lfsr(lf);
			{en, wg} = lf[7:2];
			lf = lfsr(lf);
			pt = lf[2:0];
			@(posedge clk);
			timer_enabled <= 1'b1;
			wg_level      <= wg;
			port_level    <= pt;
			sd = {1'b0, en, 1'b0, m[2:0]};
			wr(`IDX_WAVEFORM_SETUP, sd);
			rd(`IDX_WAVEFORM_SETUP, sd);
			settle(2);
			vm = (m == 1 || m == 3 || m >= 5);
			ov = {3{vm}} & en;
			`CHK("top_cmp0", m == 1, top_from_compare0)
			`CHK("upd_bot", m == 3 || m >= 5, update_at_bottom)
			`CHK("ovf_top", m != 3 && m != 7, overflow_at_top)
			`CHK("ovf_bot", m == 3 || m >= 6, overflow_at_bottom)
			`CHK("override", ov, pin_override)
			`CHK("pin", (ov & wg) | (~ov & pt), waveform_output_pin)
		end
		// Write with lane zero off is dropped.
		bus(1'b1, `IDX_WAVEFORM_SETUP, 8'h00, 4'h0);
		rd(`IDX_WAVEFORM_SETUP, sd);
		wr(`IDX_SPLIT_CONTROL, 8'h01);
		rd(`IDX_SPLIT_CONTROL, 8'h01);
		settle(1);
		`CHK("split", 1'b1, split_mode)
		@(posedge clk);
		timer_enabled <= 1'b0;
		wr(`IDX_OUTPUT_LEVELS, 8'h05);
		rd(`IDX_OUTPUT_LEVELS, 8'h05);
		settle(2);
		`CHK("level", 3'h5, waveform_level)
		@(posedge clk);
		timer_enabled <= 1'b1;
		wr(`IDX_OUTPUT_LEVELS, 8'h02);
		rd(`IDX_OUTPUT_LEVELS, 8'h05);
		settle(2);
		`CHK("level_run", wg, waveform_level)
		wr(`IDX_WAVEFORM_SETUP, 8'h03);
		wr(`IDX_STATUS_SET, 8'h01);
		settle(1);
		`CHK("dir", 1'b1, count_down)
		rd(`IDX_STATUS_CLEAR, 8'h01);
		wr(`IDX_STATUS_SET, 8'h02);
		rd(`IDX_STATUS_SET, 8'h03);
		wr(`IDX_STATUS_CLEAR, 8'h01);
		rd(`IDX_STATUS_CLEAR, 8'h02);
		wr(`IDX_STATUS_CLEAR, 8'h02);
		pulse(2, 3'h1);
		settle(1);
		`CHK("dir_hw", 1'b1, count_down)
		wr(`IDX_STATUS_CLEAR, 8'h01);
		rd(`IDX_STATUS_SET, 8'h00);
		pulse(0, 3'h1);
		settle(0);
		`CHK("valid", 3'h1, buffer_valid_flag)
		pulse(1, 3'h0);
		settle(2);
		`CHK("copy", 1, n_copy)
		`CHK("valid_clr", 3'h0, buffer_valid_flag)
		wr(`IDX_STATUS_SET, 8'h02);
		pulse(0, 3'h2);
		pulse(1, 3'h0);
		settle(2);
		`CHK("copy_lock", 1, n_copy)
		`CHK("valid_keep", 3'h2, buffer_valid_flag)
		rd(`IDX_STATUS_SET, 8'h02);
		wr(`IDX_STATUS_CLEAR, 8'h02);
		pulse(1, 3'h0);
		// Automatic lock with channels 0 and 1 enabled.
		wr(`IDX_WAVEFORM_SETUP, 8'h3B);
		rd(`IDX_STATUS_SET, 8'h02);
		pulse(0, 3'h1);
		rd(`IDX_STATUS_SET, 8'h02);
		pulse(0, 3'h2);
		rd(`IDX_STATUS_CLEAR, 8'h00);
		pulse(1, 3'h0);
		settle(2);
		`CHK("copy_auto", 3, n_copy)
		rd(`IDX_STATUS_SET, 8'h02);
		wr(`IDX_WAVEFORM_SETUP, 8'h03);
		wr(`IDX_STATUS_CLEAR, 8'h02);
		// Commands through both registers; hard reset refused while running.
		for (int c = 1; c < 4; c++) begin
			wr(c[0] ? `IDX_STATUS_SET : `IDX_STATUS_CLEAR, {4'h0, c[1:0], 2'b00});
			rd(`IDX_STATUS_SET, 8'h00);
		end
		settle(1);
		`CHK("cmds", {32'd1, 32'd1, 32'd0}, {n_upd, n_rst, n_hrd})
		@(posedge clk);
		timer_enabled <= 1'b0;
		wr(`IDX_STATUS_SET, 8'h0C);
		settle(1);
		`CHK("hard_rst", 1, n_hrd)
		rd(`IDX_WAVEFORM_SETUP, 8'h00);
		rd(`IDX_SPLIT_CONTROL, 8'h00);
		settle(2);
		wrap_up();
	end

endmodule
